// ==== verilog/mpp_pkg.sv ====
// constants for the multiplexed parallel memory port
package mpp_pkg;
    localparam int ADDR_W = 24;
    localparam int PIN_W = 16;
    localparam int UPPER_LSB = 8;
    localparam int UPPER_W = 16;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic ALE_POL_RESET = 1'h1;
    localparam int ALE_CYCLES = 2;
    localparam int STROBE_CYCLES = 3;
    localparam int HOLD_CYCLES = 1;
    localparam int CNT_W = 4;
    typedef enum logic [2:0] {
        MPP_RESET = 3'h0,
        MPP_IDLE = 3'h1,
        MPP_ADDR = 3'h2,
        MPP_GAP = 3'h3,
        MPP_STROBE = 3'h4,
        MPP_HOLD = 3'h5
    } mpp_state_type;
endpackage

// ==== verilog/mpp_buf.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module mpp_buf #(
    parameter int WIDTH = 42
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;
    logic ready_q, ready_d;

    if (WIDTH < 1)
    begin : g_width_chk
        $error("buffer width must be positive");
    end

    always_comb
    begin
        push = in_valid_in && ready_q;
        pop = out_ready_in && (cnt_q != 2'h0);
        mem_d = mem_q;
        if (push)
        begin
            mem_d[wr_q] = in_data_in;
        end
        wr_d = push ? ~wr_q : wr_q;
        rd_d = pop ? ~rd_q : rd_q;
        cnt_d = cnt_q + {1'h0, push} - {1'h0, pop};
        ready_d = (cnt_d != 2'h2);
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q <= 1'h0;
            rd_q <= 1'h0;
            cnt_q <= 2'h0;
            ready_q <= 1'h0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    assign in_ready_out = ready_q;
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out = mem_q[rd_q];
endmodule
`default_nettype wire

// ==== verilog/mpp_port.sv ====
// multiplexed parallel port engine driving shared address/data pins
// Behaviour
// - address and data share sixteen pins; latch strobe marks address phase
// - supports 8-bit and 16-bit transfer width modes
// - 8-bit mode pulses latch strobe whenever upper address bits change
// - read strobe held low during every read
// - write strobe held low during every write
// - latch strobe asserted whenever an address goes to the external latch; on 8-bit reads the low address byte goes out without it
// - latch strobe active high after reset; software may make it active low
// - flag use of pins keeps all three strobes inactive
`timescale 1ns/1ns
`default_nettype none
module mpp_port (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic req_write_in,
    input wire logic [mpp_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [mpp_pkg::PIN_W-1:0] req_wdata_in,
    input wire logic [1:0] width_mode_in,
    input wire logic ale_active_low_in,
    input wire logic flag_mode_in,
    input wire logic [mpp_pkg::PIN_W-1:0] flag_out_value_in,
    input wire logic [mpp_pkg::PIN_W-1:0] flag_out_enable_in,
    output logic [mpp_pkg::PIN_W-1:0] flag_in_value_out,
    output logic rd_valid_out,
    output logic [mpp_pkg::PIN_W-1:0] rd_data_out,
    input wire logic [mpp_pkg::PIN_W-1:0] shared_addr_data_pins_in,
    output logic [mpp_pkg::PIN_W-1:0] shared_addr_data_pins_out,
    output logic [mpp_pkg::PIN_W-1:0] shared_addr_data_pins_oe_out,
    output logic rd_n_out,
    output logic rd_n_oe_out,
    output logic wr_n_out,
    output logic wr_n_oe_out,
    output logic ale_out,
    output logic ale_oe_out,
    output logic busy_out
);
    localparam int BW = 1 + mpp_pkg::ADDR_W + mpp_pkg::PIN_W + 2;
    localparam int PW = mpp_pkg::PIN_W;

    ////////////////////////////////////////////////////////////////////////
    // request buffer
    logic buf_valid, buf_ready;
    logic [BW-1:0] buf_data;

    mpp_buf #(.WIDTH(BW)) u_buf (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .in_valid_in(req_valid_in),
        .in_ready_out(req_ready_out),
        .in_data_in({req_write_in, req_addr_in, req_wdata_in, width_mode_in}),
        .out_valid_out(buf_valid),
        .out_ready_in(buf_ready),
        .out_data_out(buf_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    logic [PW-1:0] pin_s1_q, pin_s2_q;

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= shared_addr_data_pins_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer engine
    mpp_pkg::mpp_state_type st_q, st_d;
    logic [mpp_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [BW-1:0] cur_q, cur_d;
    logic [mpp_pkg::UPPER_W-1:0] upper_q, upper_d;
    logic upper_ok_q, upper_ok_d;
    logic pol_d, ale_d, ale_q;
    logic [PW-1:0] pad_q, pad_d, pad_oe_q, pad_oe_d;
    logic rd_n_q, rd_n_d, wr_n_q, wr_n_d, ale_act_q, ale_act_d, oe_q, oe_d;
    logic rdv_q, rdv_d, busy_q, busy_d;
    logic [PW-1:0] rdd_q, rdd_d, fin_q, fin_d;

    function automatic logic [mpp_pkg::UPPER_W-1:0] upper_of(
        input logic [mpp_pkg::ADDR_W-1:0] a);
        upper_of = a[mpp_pkg::ADDR_W-1:mpp_pkg::UPPER_LSB];
    endfunction

    logic c_wr;
    logic [mpp_pkg::ADDR_W-1:0] c_addr;
    logic [PW-1:0] c_wdata;
    logic [1:0] c_mode;
    logic n_wr;
    logic [mpp_pkg::ADDR_W-1:0] n_addr;
    logic [1:0] n_mode;

    assign {c_wr, c_addr, c_wdata, c_mode} = cur_q;
    assign n_wr = buf_data[BW-1];
    assign n_addr = buf_data[BW-2 -: mpp_pkg::ADDR_W];
    assign n_mode = buf_data[1:0];
    assign buf_ready = (st_q == mpp_pkg::MPP_IDLE) && !flag_mode_in;

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        cur_d = cur_q;
        upper_d = upper_q;
        upper_ok_d = upper_ok_q;
        pol_d = ale_active_low_in ? 1'h0 : 1'h1;
        pad_d = pad_q;
        pad_oe_d = pad_oe_q;
        rd_n_d = 1'h1;
        wr_n_d = 1'h1;
        ale_act_d = 1'h0;
        oe_d = 1'h1;
        rdv_d = 1'h0;
        rdd_d = rdd_q;
        busy_d = (st_q != mpp_pkg::MPP_IDLE);
        fin_d = pin_s2_q;
        unique case (st_q)
            mpp_pkg::MPP_RESET:
            begin
                st_d = mpp_pkg::MPP_IDLE;
                pad_oe_d = '0;
            end
            mpp_pkg::MPP_IDLE:
            begin
                if (flag_mode_in)
                begin
                    // strobes stay inactive while pins serve as flags
                    pad_d = flag_out_value_in;
                    pad_oe_d = flag_out_enable_in;
                    upper_ok_d = 1'h0;
                end
                else
                begin
                    pad_oe_d = '0;
                    if (buf_valid)
                    begin
                        cur_d = buf_data;
                        busy_d = 1'h1;
                        if (n_mode == mpp_pkg::WIDTH_8 && upper_ok_q &&
                            upper_of(n_addr) == upper_q)
                        begin
                            st_d = mpp_pkg::MPP_STROBE;
                            cnt_d = 4'(mpp_pkg::STROBE_CYCLES - 1);
                            rd_n_d = n_wr;
                            wr_n_d = ~n_wr;
                            // low byte goes out with the strobe
                            pad_d = {{(PW-8){1'h0}},
                                n_wr ? buf_data[9:2] : n_addr[7:0]};
                            pad_oe_d = n_wr ? '1 : {{8{1'h0}}, {8{1'h1}}};
                        end
                        else
                        begin
                            st_d = mpp_pkg::MPP_ADDR;
                            cnt_d = 4'(mpp_pkg::ALE_CYCLES - 1);
                            ale_act_d = 1'h1;
                            pad_oe_d = '1;
                            pad_d = (n_mode == mpp_pkg::WIDTH_8)
                                ? upper_of(n_addr)
                                : n_addr[PW-1:0];
                        end
                    end
                end
            end
            mpp_pkg::MPP_ADDR:
            begin
                ale_act_d = 1'h1;
                if (cnt_q == '0)
                begin
                    ale_act_d = 1'h0;
                    st_d = mpp_pkg::MPP_GAP;
                    // a 16-bit address overwrites the external latch
                    upper_d = upper_of(c_addr);
                    upper_ok_d = (c_mode == mpp_pkg::WIDTH_8);
                end
                else
                begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            mpp_pkg::MPP_GAP:
            begin
                // address held one cycle after strobe drops
                st_d = mpp_pkg::MPP_STROBE;
                cnt_d = 4'(mpp_pkg::STROBE_CYCLES - 1);
                rd_n_d = c_wr;
                wr_n_d = ~c_wr;
                if (c_mode == mpp_pkg::WIDTH_8)
                begin
                    pad_d = {{(PW-8){1'h0}}, c_wr ? c_wdata[7:0] : c_addr[7:0]};
                    pad_oe_d = c_wr ? '1 : {{8{1'h0}}, {8{1'h1}}};
                end
                else
                begin
                    pad_d = c_wdata;
                    pad_oe_d = {PW{c_wr}};
                end
            end
            mpp_pkg::MPP_STROBE:
            begin
                rd_n_d = c_wr;
                wr_n_d = ~c_wr;
                if (cnt_q == '0)
                begin
                    rd_n_d = 1'h1;
                    wr_n_d = 1'h1;
                    st_d = mpp_pkg::MPP_HOLD;
                    if (!c_wr)
                    begin
                        rdv_d = 1'h1;
                        rdd_d = (c_mode == mpp_pkg::WIDTH_8)
                            ? {{(PW-8){1'h0}}, pin_s2_q[PW-1:8]}
                            : pin_s2_q;
                    end
                end
                else
                begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            mpp_pkg::MPP_HOLD:
            begin
                st_d = mpp_pkg::MPP_IDLE;
                pad_oe_d = '0;
            end
            default:
            begin
                st_d = mpp_pkg::MPP_IDLE;
            end
        endcase
        ale_d = ale_act_d ? pol_d : ~pol_d;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q <= mpp_pkg::MPP_RESET;
            cnt_q <= '0;
            cur_q <= '0;
            upper_q <= '0;
            upper_ok_q <= 1'h0;
            ale_q <= ~mpp_pkg::ALE_POL_RESET;
            pad_q <= '0;
            pad_oe_q <= '0;
            rd_n_q <= 1'h1;
            wr_n_q <= 1'h1;
            ale_act_q <= 1'h0;
            oe_q <= 1'h0;
            rdv_q <= 1'h0;
            rdd_q <= '0;
            busy_q <= 1'h0;
            fin_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cur_q <= cur_d;
            upper_q <= upper_d;
            upper_ok_q <= upper_ok_d;
            ale_q <= ale_d;
            pad_q <= pad_d;
            pad_oe_q <= pad_oe_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            ale_act_q <= ale_act_d;
            oe_q <= oe_d;
            rdv_q <= rdv_d;
            rdd_q <= rdd_d;
            busy_q <= busy_d;
            fin_q <= fin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers
    assign ale_out = ale_q;
    assign ale_oe_out = oe_q;
    assign rd_n_out = rd_n_q;
    assign rd_n_oe_out = oe_q;
    assign wr_n_out = wr_n_q;
    assign wr_n_oe_out = oe_q;
    assign shared_addr_data_pins_out = pad_q;
    assign shared_addr_data_pins_oe_out = pad_oe_q;
    assign rd_valid_out = rdv_q;
    assign rd_data_out = rdd_q;
    assign busy_out = busy_q;
    assign flag_in_value_out = fin_q;
endmodule
`default_nettype wire

// ==== testbench/mpp_port_assertions.sv ====
// concurrent checks on the parallel port pins and strobes
`timescale 1ns/1ns
`default_nettype none
module mpp_port_chk (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ale_active_low_in,
    input wire logic flag_mode_in,
    input wire logic rd_valid_out,
    input wire logic [mpp_pkg::PIN_W-1:0] shared_addr_data_pins_oe_out,
    input wire logic rd_n_out,
    input wire logic rd_n_oe_out,
    input wire logic wr_n_out,
    input wire logic wr_n_oe_out,
    input wire logic ale_out,
    input wire logic ale_oe_out,
    input wire logic busy_out
);
    wire logic ale_act;
    assign ale_act = ale_out ^ ale_active_low_in;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////
    rd_strobe_len_a: assert property ($fell(rd_n_out) |->
        !rd_n_out [*3] ##1 rd_n_out) else $error("read strobe width");
    wr_strobe_len_a: assert property ($fell(wr_n_out) |->
        !wr_n_out [*3] ##1 wr_n_out) else $error("write strobe width");
    rd_valid_edge_a: assert property ($rose(rd_n_out) |->
        rd_valid_out) else $error("read data not flagged");
    rd_valid_src_a: assert property (rd_valid_out |->
        !$past(rd_n_out)) else $error("read flag without strobe");
    rd_pins_free_a: assert property (!rd_n_out |->
        shared_addr_data_pins_oe_out[15:8] == 8'h00)
        else $error("pins driven during read");
    wr_pins_drive_a: assert property (!wr_n_out |->
        &shared_addr_data_pins_oe_out[7:0]) else $error("write data undriven");
    addr_phase_a: assert property ($rose(ale_act) &&
        $stable(ale_active_low_in) |-> ale_act && rd_n_out && wr_n_out &&
        &shared_addr_data_pins_oe_out ##1 ale_act && rd_n_out && wr_n_out
        ##1 !ale_act && rd_n_out && wr_n_out)
        else $error("address phase shape");
    flag_quiet_a: assert property (flag_mode_in && !busy_out &&
        $stable(ale_active_low_in) |-> rd_n_out && wr_n_out && !ale_act)
        else $error("strobe active in flag mode");
    strobe_drive_a: assert property (!$past(rst_in) |->
        rd_n_oe_out && wr_n_oe_out && ale_oe_out)
        else $error("strobe undriven");
endmodule
bind mpp_port mpp_port_chk u_chk (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ale_active_low_in(ale_active_low_in),
    .flag_mode_in(flag_mode_in),
    .rd_valid_out(rd_valid_out),
    .shared_addr_data_pins_oe_out(shared_addr_data_pins_oe_out),
    .rd_n_out(rd_n_out),
    .rd_n_oe_out(rd_n_oe_out),
    .wr_n_out(wr_n_out),
    .wr_n_oe_out(wr_n_oe_out),
    .ale_out(ale_out),
    .ale_oe_out(ale_oe_out),
    .busy_out(busy_out)
);
`default_nettype wire

// ==== testbench/mpp_mem_model.sv ====
// external memory with upper address latch on the shared pins
`timescale 1ns/1ns
`default_nettype none
module mpp_mem_model (
    input wire logic clock_in,
    input wire logic mode16_in,
    input wire logic ale_active_low_in,
    input wire logic slow_in,
    input wire logic ale_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [15:0] pins_in,
    output logic [15:0] pins_out,
    output logic [15:0] pins_oe_out
);
    logic [15:0] latch_q = 16'h0000;
    logic [15:0] mem [logic [15:0]];
    initial
    begin
        pins_out = 16'h0000;
        pins_oe_out = 16'h0000;
    end
    always @(negedge clock_in)
    begin
        if (ale_in ^ ale_active_low_in)
            latch_q = pins_in;
        if (!wr_n_in && mode16_in)
            mem[latch_q] = pins_in;
    end
    always @(negedge rd_n_in)
    begin
        #1;
        if (slow_in)
            #3;
        if (mode16_in)
            pins_out = mem.exists(latch_q) ? mem[latch_q] : latch_q ^ 16'h5a5a;
        else
            pins_out = {latch_q[7:0] ^ latch_q[15:8] ^ pins_in[7:0], 8'h00};
        pins_oe_out = mode16_in ? 16'hffff : 16'hff00;
    end
    always @(posedge rd_n_in)
        pins_oe_out = 16'h0000;
endmodule
`default_nettype wire

// ==== testbench/tb_muxed_parallel_memory_port.sv ====
// self-checking bench for the multiplexed parallel memory port
`timescale 1ns/1ns
`default_nettype none
module tb_muxed_parallel_memory_port;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [23:0] req_addr_in = 24'h00_0000;
    logic [15:0] req_wdata_in = 16'h0000;
    logic [1:0] width_mode_in = mpp_pkg::WIDTH_16;
    logic ale_active_low_in = 1'b0;
    logic flag_mode_in = 1'b0;
    logic [15:0] flag_val = 16'h0000;
    logic [15:0] flag_en = 16'h0000;
    logic req_ready_out, rd_valid_out, busy_out, slow = 1'b0;
    logic rd_n_out, rd_n_oe_out, wr_n_out, wr_n_oe_out, ale_out, ale_oe_out;
    logic [15:0] flag_in_value_out, rd_data_out, dut_out, dut_oe;
    logic [15:0] mem_out, mem_oe, d;
    wire logic [15:0] pins;
    int fail_count = 0, checks_done = 0, cycles = 0, ale_rises = 0;
    int off8[5] = '{0, 1, 5, 256, 300};
    logic ale_prev = 1'b0;
    logic [16:0] e;
    logic [16:0] exp_q[$];
    logic [15:0] mem [logic [15:0]];
    logic [23:0] a [5];
    logic [23:0] b;
    // pull-ups hold released pins high
    assign pins = (dut_oe & dut_out) | (~dut_oe & mem_oe & mem_out) |
        (~dut_oe & ~mem_oe);
    always #5 clock_in = ~clock_in;
    mpp_port dut (.clock_in(clock_in), .rst_in(rst_in),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .width_mode_in(width_mode_in),
        .ale_active_low_in(ale_active_low_in), .flag_mode_in(flag_mode_in),
        .flag_out_value_in(flag_val), .flag_out_enable_in(flag_en),
        .flag_in_value_out(flag_in_value_out), .rd_valid_out(rd_valid_out),
        .rd_data_out(rd_data_out), .shared_addr_data_pins_in(pins),
        .shared_addr_data_pins_out(dut_out),
        .shared_addr_data_pins_oe_out(dut_oe), .rd_n_out(rd_n_out),
        .rd_n_oe_out(rd_n_oe_out), .wr_n_out(wr_n_out),
        .wr_n_oe_out(wr_n_oe_out), .ale_out(ale_out),
        .ale_oe_out(ale_oe_out), .busy_out(busy_out));
    mpp_mem_model u_mem (.clock_in(clock_in),
        .mode16_in(width_mode_in == mpp_pkg::WIDTH_16),
        .ale_active_low_in(ale_active_low_in), .slow_in(slow),
        .ale_in(ale_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
        .pins_in(pins), .pins_out(mem_out), .pins_oe_out(mem_oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic push(input logic wr, input logic [23:0] ad,
                        input logic [15:0] wd, input logic [1:0] m);
        @(negedge clock_in);
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_addr_in = ad;
        req_wdata_in = wd;
        width_mode_in = m;
        slow = 1'($urandom);
        if (wr && m != mpp_pkg::WIDTH_8)
            mem[ad[15:0]] = wd;
        else if (!wr && m == mpp_pkg::WIDTH_8)
            exp_q.push_back({9'h100, ad[7:0] ^ ad[15:8] ^ ad[23:16]});
        else if (!wr)
            exp_q.push_back({1'b0, mem.exists(ad[15:0]) ? mem[ad[15:0]] :
                ad[15:0] ^ 16'h5a5a});
        while (req_ready_out !== 1'b1)
            @(negedge clock_in);
        @(posedge clock_in);
    endtask
    task automatic idle();
        @(negedge clock_in);
        req_valid_in = 1'b0;
        repeat (4) @(negedge clock_in);
        while (busy_out !== 1'b0)
            @(negedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clock_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            final_report();
        end
        ale_prev <= ale_out ^ ale_active_low_in;
        if ((ale_out ^ ale_active_low_in) && !ale_prev)
            ale_rises++;
        if (rd_valid_out === 1'b1 && exp_q.size() == 0)
            check(16'h0001, 16'h0000);
        else if (rd_valid_out === 1'b1)
        begin
            e = exp_q.pop_front();
            check(rd_data_out, e[15:0]);
        end
    end
    initial
    begin
        void'($urandom(32'h0000_56dc));
        repeat (6) @(posedge clock_in);
        #1;
        check(dut_oe | {13'h0000, rd_n_oe_out, wr_n_oe_out, ale_oe_out},
            16'h0000);
        @(negedge clock_in);
        rst_in = 1'b0;
        repeat (2) @(negedge clock_in);
        check({10'h000, rd_n_oe_out, wr_n_oe_out, ale_oe_out, rd_n_out,
            wr_n_out, ale_out}, 16'h003e);
        check(dut_oe, 16'h0000);
        for (int i = 0; i < 5; i++)
            a[i] = 24'($urandom);
        for (int i = 0; i < 4; i++)
            push(1'b1, a[i], 16'($urandom), mpp_pkg::WIDTH_16);
        for (int i = 0; i < 5; i++)
            push(1'b0, a[i], 16'h0000, mpp_pkg::WIDTH_16);
        idle();
        check(16'(ale_rises), 16'h0009);
        ale_rises = 0;
        b = 24'($urandom) & 24'hff_ff80;
        foreach (off8[i])
            push(1'b0, 24'(b + off8[i]), 16'h0000, mpp_pkg::WIDTH_8);
        push(1'b1, 24'(b + 301), 16'($urandom), mpp_pkg::WIDTH_8);
        idle();
        check(16'(ale_rises), 16'h0002);
        ale_active_low_in = 1'b1;
        repeat (3) @(negedge clock_in);
        check({15'h0000, ale_out}, 16'h0001);
        ale_rises = 0;
        d = 16'($urandom);
        push(1'b1, a[0], d, mpp_pkg::WIDTH_16);
        push(1'b0, a[0], 16'h0000, mpp_pkg::WIDTH_16);
        idle();
        push(1'b0, 24'(b + 300), 16'h0000, mpp_pkg::WIDTH_8);
        idle();
        check(16'(ale_rises), 16'h0003);
        ale_active_low_in = 1'b0;
        flag_mode_in = 1'b1;
        flag_val = 16'($urandom);
        flag_en = 16'($urandom);
        repeat (6) @(negedge clock_in);
        check(flag_in_value_out, (flag_val & flag_en) | ~flag_en);
        push(1'b0, a[1], 16'h0000, mpp_pkg::WIDTH_16);
        push(1'b0, a[2], 16'h0000, mpp_pkg::WIDTH_16);
        @(negedge clock_in);
        check({14'h0000, req_ready_out, busy_out}, 16'h0000);
        check({14'h0000, rd_n_out, wr_n_out}, 16'h0003);
        req_valid_in = 1'b0;
        flag_mode_in = 1'b0;
        flag_en = 16'h0000;
        idle();
        check(16'(exp_q.size()), 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
